// [rtl/vgm_mailbox.sv]
/*
  Host mailbox of the vector generator: control and flag status locations,
  DMA pointer register, coprocessor self-test sequencer, interrupt logic.
  Assumes an AXI4-Lite master on clk, and a drive board that loops the
  master clock back on the integration clock return input.
*/
// The AXI4-Lite slave port is implemented in this module.
module vgm_mailbox
  import vgm_pkg::*;
#(
  parameter int MOTION_GAP_CYC = VGM_MOTION_GAP_CYC,
  parameter int MCK_HALF_CYC   = VGM_MCK_HALF_CYC
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [VGM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [VGM_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic      [1:0]            s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [VGM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // AXI4-Lite read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic      [VGM_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  // Drive board clock loop
  output logic                       master_clock_out,
  input  wire logic                  integration_clock_return,
  // Interrupt
  output logic                       irq
);

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  if (MOTION_GAP_CYC < 1 || MOTION_GAP_CYC > 65535)
  begin : g_bad_gap
    $error("motion gap count out of range");
  end
  if (MCK_HALF_CYC < 1 || MCK_HALF_CYC > 65535)
  begin : g_bad_mck
    $error("master clock half period out of range");
  end

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic                  aw_hold_q;
  logic [VGM_ADDR_W-1:0] awaddr_q;
  logic                  w_hold_q;
  logic [7:0]            wdata_q;
  logic                  wstrb0_q;
  logic                  do_write;
  logic                  wr_hit;
  logic                  rd_take;
  logic                  rd_status;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [VGM_DATA_W-1:0] rdata_q;
  logic [1:0]            rresp_q;
  logic [7:0]            control_q;
  logic [7:0]            dma_ptr_q;
  logic [2:0]            flag_q;
  logic [VGM_IRQ_W-1:0]  int_stat_q;
  logic [VGM_IRQ_W-1:0]  int_mask_q;
  logic [VGM_IRQ_W-1:0]  int_set;
  vgm_state_t            state_q;
  logic                  done_q;
  logic                  post_en;
  logic [2:0]            post_code;
  logic                  copro_reset_q;
  logic                  copro_rst_prev_q;
  logic                  release_start;
  logic [15:0]           gap_cnt_q;
  logic [15:0]           mck_cnt_q;
  logic                  mck_q;
  logic                  ic_meta_q;
  logic                  ic_samp_q;
  logic                  ic_prev_q;
  logic                  ic_edge;
  logic                  ram_we;
  logic                  ram_re;
  logic [7:0]            ram_rdata;
  logic [7:0]            status_byte;

  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_hit        = (awaddr_q == VGM_ADDR_CONTROL) || (awaddr_q == VGM_ADDR_DMA_PTR)
                      || (awaddr_q == VGM_ADDR_INT_STATUS) || (awaddr_q == VGM_ADDR_INT_MASK);

  // Address and data capture, in either order
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      else if (do_write)
      begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= VGM_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? VGM_RESP_OKAY : VGM_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign rd_take       = s_axi_arvalid && !rvalid_q;
  assign rd_status     = rd_take && (s_axi_araddr == VGM_ADDR_STATUS);
  assign status_byte   = {flag_q, 3'h0, done_q, (state_q != VGM_ST_IDLE)
                          && (state_q != VGM_ST_DONE)};

  // Read data decode and response
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= VGM_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= VGM_RESP_OKAY;
      unique case (s_axi_araddr)
        VGM_ADDR_CONTROL:    rdata_q <= {24'h00_0000, control_q};
        VGM_ADDR_STATUS:     rdata_q <= {24'h00_0000, status_byte};
        VGM_ADDR_DMA_PTR:    rdata_q <= {24'h00_0000, dma_ptr_q};
        VGM_ADDR_INT_STATUS: rdata_q <= {29'h0000_0000, int_stat_q};
        VGM_ADDR_INT_MASK:   rdata_q <= {29'h0000_0000, int_mask_q};
        default:
        begin
          rdata_q <= '0;
          rresp_q <= VGM_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------

  // Control and DMA pointer, byte lane 0 only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      control_q <= VGM_CONTROL_RST;
      dma_ptr_q <= VGM_DMA_PTR_RST;
    end
    else if (do_write && wstrb0_q)
    begin
      if (awaddr_q == VGM_ADDR_CONTROL)
      begin
        control_q <= wdata_q;
      end
      if (awaddr_q == VGM_ADDR_DMA_PTR)
      begin
        dma_ptr_q <= wdata_q;
      end
    end
  end

  // Coprocessor reset and release detection
  assign release_start = copro_rst_prev_q && !copro_reset_q
                      && control_q[VGM_CTL_SELF_TEST_BIT];
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      copro_reset_q    <= 1'b1;
      copro_rst_prev_q <= 1'b1;
    end
    else
    begin
      copro_reset_q    <= control_q[VGM_CTL_RESET_BIT];
      copro_rst_prev_q <= copro_reset_q;
    end
  end

  // --------------------------------------------------------------------
  // Flag location: one code at a time, cleared by a status read
  // --------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset || copro_reset_q)
    begin
      flag_q <= VGM_FLAG_NONE;
    end
    else if (post_en)
    begin
      flag_q <= post_code;
    end
    else if (rd_status)
    begin
      flag_q <= VGM_FLAG_NONE;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status, mask and output
  // --------------------------------------------------------------------
  assign int_set[VGM_IRQ_TC]   = post_en && (post_code == VGM_FLAG_TASK_COMPLETE);
  assign int_set[VGM_IRQ_SYNC] = post_en && (post_code == VGM_FLAG_MOTION_SYNC);
  assign int_set[VGM_IRQ_ERR]  = post_en && (post_code == VGM_FLAG_MOTION_ERROR);

  // Sticky bits, write one to clear, a new event wins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      int_stat_q <= '0;
      int_mask_q <= VGM_INT_MASK_RST[VGM_IRQ_W-1:0];
    end
    else
    begin
      if (do_write && wstrb0_q && awaddr_q == VGM_ADDR_INT_STATUS)
      begin
        int_stat_q <= (int_stat_q & ~wdata_q[VGM_IRQ_W-1:0]) | int_set;
      end
      else
      begin
        int_stat_q <= int_stat_q | int_set;
      end
      if (do_write && wstrb0_q && awaddr_q == VGM_ADDR_INT_MASK)
      begin
        int_mask_q <= wdata_q[VGM_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // --------------------------------------------------------------------
  // Integration clock loop
  // --------------------------------------------------------------------

  // Master clock divider driven to the drive board
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mck_cnt_q <= '0;
      mck_q     <= 1'b0;
    end
    else if (mck_cnt_q == 16'(MCK_HALF_CYC - 1))
    begin
      mck_cnt_q <= '0;
      mck_q     <= !mck_q;
    end
    else
    begin
      mck_cnt_q <= mck_cnt_q + 16'h0001;
    end
  end

  assign master_clock_out = mck_q;

  // Returning clock registered twice, edge taken after the second stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ic_meta_q <= 1'b0;
      ic_samp_q <= 1'b0;
      ic_prev_q <= 1'b0;
    end
    else
    begin
      ic_meta_q <= integration_clock_return;
      ic_samp_q <= ic_meta_q;
      ic_prev_q <= ic_samp_q;
    end
  end

  assign ic_edge = ic_samp_q != ic_prev_q;

  // --------------------------------------------------------------------
  // Scratch RAM
  // --------------------------------------------------------------------
  assign ram_we = state_q == VGM_ST_RAM_WR;
  assign ram_re = state_q == VGM_ST_RAM_RD;

  vgm_scratch_ram #(
    .DATA_W (VGM_REG_W),
    .DEPTH  (VGM_RAM_DEPTH),
    .AW     (VGM_RAM_AW)
  ) u_ram (
    .clk       (clk),
    .reset     (reset),
    .wr_en     (ram_we),
    .wr_addr   (VGM_RAM_TEST_ADDR),
    .wr_data   (VGM_RAM_PATTERN),
    .rd_en     (ram_re),
    .rd_addr   (VGM_RAM_TEST_ADDR),
    .rd_data_q (ram_rdata)
  );

  // --------------------------------------------------------------------
  // Self-test sequencer posting codes
  // --------------------------------------------------------------------
  always_comb
  begin
    post_en   = 1'b0;
    post_code = VGM_FLAG_NONE;
    unique case (state_q)
      VGM_ST_IDLE:
      begin
        post_en   = release_start;
        post_code = VGM_FLAG_TASK_COMPLETE;
      end
      VGM_ST_TC_WAIT:
      begin
        post_en   = flag_q == VGM_FLAG_NONE;
        post_code = VGM_FLAG_MOTION_SYNC;
      end
      VGM_ST_GAP:
      begin
        post_en   = gap_cnt_q == 16'h0000;
        post_code = VGM_FLAG_MOTION_ERROR;
      end
      VGM_ST_CLK_POLL:
      begin
        post_en   = ic_edge;
        post_code = VGM_FLAG_TASK_COMPLETE;
      end
      VGM_ST_RAM_CHK:
      begin
        post_en   = ram_rdata == VGM_RAM_PATTERN;
        post_code = VGM_FLAG_TASK_COMPLETE;
      end
      VGM_ST_DMA_CHK:
      begin
        post_en   = dma_ptr_q == VGM_DMA_PATTERN;
        post_code = VGM_FLAG_TASK_COMPLETE;
      end
      default:
      begin
        post_en   = 1'b0;
        post_code = VGM_FLAG_NONE;
      end
    endcase
  end

  // Sequencer state, each posted code waits for the host read
  always_ff @(posedge clk)
  begin
    if (reset || copro_reset_q)
    begin
      state_q   <= VGM_ST_IDLE;
      gap_cnt_q <= '0;
      done_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        VGM_ST_IDLE:      if (release_start) state_q <= VGM_ST_TC_WAIT;
        VGM_ST_TC_WAIT:   if (post_en) state_q <= VGM_ST_SYNC_WAIT;
        VGM_ST_SYNC_WAIT:
        begin
          gap_cnt_q <= 16'(MOTION_GAP_CYC - 1);
          if (flag_q == VGM_FLAG_NONE) state_q <= VGM_ST_GAP;
        end
        VGM_ST_GAP:
        begin
          gap_cnt_q <= gap_cnt_q - 16'h0001;
          if (post_en) state_q <= VGM_ST_ERR_WAIT;
        end
        VGM_ST_ERR_WAIT:  if (flag_q == VGM_FLAG_NONE) state_q <= VGM_ST_CLK_POLL;
        VGM_ST_CLK_POLL:  if (post_en) state_q <= VGM_ST_CLK_WAIT;
        VGM_ST_CLK_WAIT:  if (flag_q == VGM_FLAG_NONE) state_q <= VGM_ST_RAM_WR;
        VGM_ST_RAM_WR:    state_q <= VGM_ST_RAM_RD;
        VGM_ST_RAM_RD:    state_q <= VGM_ST_RAM_CHK;
        VGM_ST_RAM_CHK:   state_q <= post_en ? VGM_ST_RAM_WAIT : VGM_ST_RAM_WR;
        VGM_ST_RAM_WAIT:  if (flag_q == VGM_FLAG_NONE) state_q <= VGM_ST_DMA_CHK;
        VGM_ST_DMA_CHK:   if (post_en) state_q <= VGM_ST_DMA_WAIT;
        VGM_ST_DMA_WAIT:
        begin
          if (flag_q == VGM_FLAG_NONE)
          begin
            state_q <= VGM_ST_DONE;
            done_q  <= 1'b1;
          end
        end
        VGM_ST_DONE:      state_q <= VGM_ST_DONE;
        default:          state_q <= VGM_ST_IDLE;
      endcase
    end
  end

endmodule

// [rtl/vgm_scratch_ram.sv]
/*
  Small scratch RAM of the coprocessor: synchronous write, registered read.
  Assumes one clock and a synchronous active-high reset of the read register.
*/
module vgm_scratch_ram
  import vgm_pkg::*;
#(
  parameter int DATA_W = VGM_REG_W,
  parameter int DEPTH  = VGM_RAM_DEPTH,
  parameter int AW     = VGM_RAM_AW
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port
  input  wire logic              rd_en,
  input  wire logic [AW-1:0]     rd_addr,
  output logic      [DATA_W-1:0] rd_data_q
);

  // --------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------
  if (DEPTH > (1 << AW) || DEPTH < 1)
  begin : g_bad
    $error("scratch ram depth does not fit address width");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_data_q <= '0;
    end
    else if (rd_en)
    begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

// [shared/vgm_pkg.sv]
/*
  Constants, register map and state type of the vector generator host mailbox.
  Assumes a single 100 MHz system clock and AXI4-Lite register access.
*/
package vgm_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int VGM_ADDR_W = 18;
  localparam int VGM_DATA_W = 32;
  localparam int VGM_REG_W  = 8;

  // ----------------------------------------------------------------------
  // Register indexes and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] VGM_IDX_CONTROL    = 16'hFDF0;
  localparam logic [15:0] VGM_IDX_STATUS     = 16'hFDF1;
  localparam logic [15:0] VGM_IDX_DMA_PTR    = 16'hFDF2;
  localparam logic [15:0] VGM_IDX_INT_STATUS = 16'hFDF4;
  localparam logic [15:0] VGM_IDX_INT_MASK   = 16'hFDF5;

  localparam logic [17:0] VGM_ADDR_CONTROL    = {VGM_IDX_CONTROL, 2'h0};
  localparam logic [17:0] VGM_ADDR_STATUS     = {VGM_IDX_STATUS, 2'h0};
  localparam logic [17:0] VGM_ADDR_DMA_PTR    = {VGM_IDX_DMA_PTR, 2'h0};
  localparam logic [17:0] VGM_ADDR_INT_STATUS = {VGM_IDX_INT_STATUS, 2'h0};
  localparam logic [17:0] VGM_ADDR_INT_MASK   = {VGM_IDX_INT_MASK, 2'h0};

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int VGM_CTL_RESET_BIT     = 0;
  localparam int VGM_CTL_SELF_TEST_BIT = 6;
  localparam int VGM_STAT_BUSY_BIT     = 0;
  localparam int VGM_STAT_DONE_BIT     = 1;
  localparam int VGM_STAT_FLAG_LSB     = 5;

  localparam logic [7:0] VGM_CONTROL_RST  = 8'h01;
  localparam logic [7:0] VGM_DMA_PTR_RST  = 8'h00;
  localparam logic [7:0] VGM_INT_MASK_RST = 8'h00;

  // Flag codes in status bits 7:5
  localparam logic [2:0] VGM_FLAG_NONE          = 3'h0;
  localparam logic [2:0] VGM_FLAG_TASK_COMPLETE = 3'h4;
  localparam logic [2:0] VGM_FLAG_MOTION_SYNC   = 3'h2;
  localparam logic [2:0] VGM_FLAG_MOTION_ERROR  = 3'h1;

  // Interrupt status bits
  localparam int VGM_IRQ_W    = 3;
  localparam int VGM_IRQ_TC   = 0;
  localparam int VGM_IRQ_SYNC = 1;
  localparam int VGM_IRQ_ERR  = 2;

  // ----------------------------------------------------------------------
  // Self-test patterns
  // ----------------------------------------------------------------------
  localparam logic [7:0] VGM_DMA_PATTERN = 8'hAA;
  localparam logic [7:0] VGM_RAM_PATTERN = 8'h5A;
  localparam int         VGM_RAM_DEPTH   = 16;
  localparam int         VGM_RAM_AW      = 4;
  localparam logic [3:0] VGM_RAM_TEST_ADDR = 4'hF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int VGM_CLK_PERIOD_NS   = 10;
  localparam int VGM_MOTION_GAP_US   = 128;
  localparam int VGM_MOTION_GAP_CYC  =
    (VGM_MOTION_GAP_US * 1000 + VGM_CLK_PERIOD_NS - 1) / VGM_CLK_PERIOD_NS;
  localparam int VGM_MCK_HALF_CYC    = 8;

  // AXI responses
  localparam logic [1:0] VGM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VGM_RESP_SLVERR = 2'h2;

  // Coprocessor self-test sequencer
  typedef enum logic [3:0] {
    VGM_ST_IDLE,
    VGM_ST_TC_WAIT,
    VGM_ST_SYNC_WAIT,
    VGM_ST_GAP,
    VGM_ST_ERR_WAIT,
    VGM_ST_CLK_POLL,
    VGM_ST_CLK_WAIT,
    VGM_ST_RAM_WR,
    VGM_ST_RAM_RD,
    VGM_ST_RAM_CHK,
    VGM_ST_RAM_WAIT,
    VGM_ST_DMA_CHK,
    VGM_ST_DMA_WAIT,
    VGM_ST_DONE
  } vgm_state_t;

endpackage

// [testbench/vgm_clock_loop.sv]
/*
  Drive board model: loops the master clock back as the integration clock.
  Assumes the bench opens or closes the loop through loop_en.
*/
module vgm_clock_loop
(
  // Loop
  input  wire logic master_clock_out,
  input  wire logic loop_en,
  output logic      integration_clock_return
);
  timeunit 1ns;
  timeprecision 100ps;
  // Delayed copy of the clock, held low while the loop is cut
  assign #3 integration_clock_return = loop_en & master_clock_out;
endmodule

// [testbench/vgm_mailbox_monitor.sv]
/*
  Protocol and flag checker of the host mailbox.
  Assumes it is bound to the mailbox top module.
*/
module vgm_mailbox_monitor
  import vgm_pkg::*;
#(
  parameter int MCK_HALF_CYC = VGM_MCK_HALF_CYC
)
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // Bus
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [VGM_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_rvalid,
  input wire logic [VGM_DATA_W-1:0] s_axi_rdata,
  // Clock loop
  input wire logic                  master_clock_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic       st_q;
  logic       mck_q;
  logic [7:0] cnt_q;
  // Remember status reads, count master clock half periods
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q  <= 1'b0;
      mck_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
        st_q <= (s_axi_araddr == VGM_ADDR_STATUS);
      mck_q <= master_clock_out;
      cnt_q <= (master_clock_out != mck_q) ? 8'h01 : cnt_q + 8'h01;
    end
  end
  a_status_code: assert property (s_axi_rvalid && st_q |-> $onehot0(s_axi_rdata[7:5]))
    else $error("two flag codes at once");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_resp: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_mck_period: assert property (cnt_q <= MCK_HALF_CYC)
    else $error("master clock stalled");
  a_mck_change: assert property (master_clock_out != mck_q |-> cnt_q == MCK_HALF_CYC)
    else $error("master clock half period short");
endmodule

// [testbench/vgm_mailbox_tb.sv]
/*
  Self-checking bench of the host mailbox: bus tasks, self-test walk.
  Assumes the package, mailbox, monitor and clock loop are compiled first.
*/
module vgm_mailbox_tb
  import vgm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  s_axi_awvalid = 1'b0;
  logic                  s_axi_awready;
  logic [VGM_ADDR_W-1:0] s_axi_awaddr = '0;
  logic [2:0]            s_axi_awprot = 3'h0;
  logic                  s_axi_wvalid = 1'b0;
  logic                  s_axi_wready;
  logic [VGM_DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic                  s_axi_bvalid;
  logic                  s_axi_bready = 1'b1;
  logic [1:0]            s_axi_bresp;
  logic                  s_axi_arvalid = 1'b0;
  logic                  s_axi_arready;
  logic [VGM_ADDR_W-1:0] s_axi_araddr = '0;
  logic [2:0]            s_axi_arprot = 3'h0;
  logic                  s_axi_rvalid;
  logic                  s_axi_rready = 1'b1;
  logic [VGM_DATA_W-1:0] s_axi_rdata;
  logic [1:0]            s_axi_rresp;
  logic                  master_clock_out;
  logic                  integration_clock_return;
  logic                  loop_en = 1'b0;
  logic                  irq;
  int                    miscompares = 0;
  int                    total_checks = 0;
  // ----------------------------------------------------------------------
  // Design and drive board model
  // ----------------------------------------------------------------------
  vgm_mailbox #(.MOTION_GAP_CYC(20), .MCK_HALF_CYC(2)) i_vgm_mailbox (
    .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .master_clock_out, .integration_clock_return, .irq);
  vgm_clock_loop i_vgm_clock_loop (.master_clock_out, .loop_en, .integration_clock_return);
  // 100 MHz clock
  always #5 clk = ~clk;
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha;
    logic hw;
    logic hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb)
    begin
      #1;
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha;
    logic hr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr)
    begin
      #1;
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ha)
        s_axi_arvalid <= 1'b0;
    end
  endtask
  // Poll status until a flag code shows or n reads pass
  task automatic want(input logic [2:0] e, input int n);
    logic [31:0] d;
    logic [1:0]  r;
    d = '0;
    for (int i = 0; i < n && d[7:5] == 3'h0; i++)
      rd(VGM_ADDR_STATUS, d, r);
    chk("flag code", {29'h0, e}, {29'h0, d[7:5]});
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(VGM_ADDR_CONTROL, d, r);
    chk("control", 32'h0000_0001, d);
    rd(VGM_ADDR_INT_MASK, d, r);
    chk("mask", 32'h0000_0000, d);
    rd(18'h0_0010, d, r);
    chk("unmapped rd", 32'h0000_0002, {30'h0, r});
    wr(18'h0_0010, 32'h0000_00FF, r);
    chk("unmapped wr", 32'h0000_0002, {30'h0, r});
    s_axi_wstrb <= 4'h0;
    wr(VGM_ADDR_CONTROL, 32'h0000_0041, r);
    s_axi_wstrb <= 4'hF;
    rd(VGM_ADDR_CONTROL, d, r);
    chk("control unstrobed", 32'h0000_0001, d);
    wr(VGM_ADDR_DMA_PTR, 32'h0000_0055, r);
    wr(VGM_ADDR_CONTROL, 32'h0000_0001, r);
    wr(VGM_ADDR_CONTROL, 32'h0000_0040, r);
    want(VGM_FLAG_TASK_COMPLETE, 20);
    rd(VGM_ADDR_INT_STATUS, d, r);
    chk("int status", 32'h0000_0003, d);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(VGM_ADDR_INT_MASK, 32'h0000_0001, r);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(VGM_ADDR_INT_STATUS, 32'h0000_0001, r);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    want(VGM_FLAG_MOTION_SYNC, 4);
    want(VGM_FLAG_NONE, 9);
    want(VGM_FLAG_MOTION_ERROR, 20);
    want(VGM_FLAG_NONE, 5);
    loop_en <= 1'b1;
    want(VGM_FLAG_TASK_COMPLETE, 20);
    want(VGM_FLAG_TASK_COMPLETE, 10);
    want(VGM_FLAG_NONE, 5);
    wr(VGM_ADDR_DMA_PTR, 32'h0000_00AA, r);
    want(VGM_FLAG_TASK_COMPLETE, 10);
    rd(VGM_ADDR_STATUS, d, r);
    chk("done", 32'h0000_0002, d);
    rd(VGM_ADDR_INT_STATUS, d, r);
    chk("int status", 32'h0000_0007, d);
    wr(VGM_ADDR_CONTROL, 32'h0000_0001, r);
    wr(VGM_ADDR_CONTROL, 32'h0000_0040, r);
    want(VGM_FLAG_TASK_COMPLETE, 20);
    close_out();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #50us;
    miscompares++;
    close_out();
  end
endmodule
bind vgm_mailbox vgm_mailbox_monitor #(.MCK_HALF_CYC(MCK_HALF_CYC)) i_vgm_mailbox_monitor (
  .clk, .reset, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rdata, .master_clock_out);
